// >>> rtl/usb_term_cfg.svh
`ifndef USB_TERM_CFG_SVH
`define USB_TERM_CFG_SVH

// register offsets
`define ADDR_FUNC_CTRL   4'h0
`define ADDR_OTG_CTRL    4'h1
`define ADDR_COMP        4'h2
`define ADDR_STATUS      4'h3

// reset values: power-up setting
`define RST_FUNC_CTRL    8'h01
`define RST_OTG_CTRL     8'h03
`define RST_COMP         8'h00

// function control field positions
`define FC_XS_LSB        0
`define FC_TS_BIT        2
`define FC_OP_LSB        3
// otg control field positions
`define OC_DP_BIT        0
`define OC_DM_BIT        1
// compensation field positions
`define CP_BOOST_LSB     0
`define CP_SQL_LSB       4

// line drive mode codes
`define OP_NORMAL        2'h0
`define OP_TRISTATE      2'h1
`define OP_NO_NRZI       2'h2

// transceiver select codes
`define XS_HS            2'h0
`define XS_FS            2'h1
`define XS_LS            2'h2

// serial bit rate divider and stuffing run length
`define BIT_DIV          4'h4
`define STUFF_RUN        3'h6

`endif

// >>> rtl/usb_term_pkg.sv
package usb_term_pkg;

  // five termination resistor enables
  typedef struct packed {
    logic plus_pullup_enable;
    logic minus_pullup_enable;
    logic plus_pulldown_enable;
    logic minus_pulldown_enable;
    logic highspeed_termination_enable;
  } term_en_s;

  // control fields that steer the termination decode
  typedef struct packed {
    logic [1:0] transceiver_select;
    logic       termination_select;
    logic [1:0] line_drive_mode;
    logic       plus_line_pulldown_request;
    logic       minus_line_pulldown_request;
  } term_ctrl_s;

  // transmit serializer states, gray along idle-data-stuff
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_DATA  = 2'b01,
    TX_STUFF = 2'b11
  } tx_state_e;

endpackage

// >>> rtl/usb_termination_decode.sv
`timescale 1ns/1ns
`include "usb_term_cfg.svh"

module usb_termination_decode (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  // register port
  input  wire logic [3:0]            addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [7:0]            rdata_o,
  // termination enables and analog knobs
  output usb_term_pkg::term_en_s     term_o,
  output logic      [2:0]            tx_amplitude_boost_o,
  output logic      [2:0]            squelch_level_adjust_o,
  // transmit stream
  input  wire logic [7:0]            tx_data_i,
  input  wire logic                  tx_valid_i,
  output logic                       tx_ready_o,
  output logic                       tx_line_o,
  output logic                       tx_active_o,
  // receive stream
  input  wire logic                  hs_rx_i,
  input  wire logic                  fs_rx_i,
  input  wire logic                  squelch_i,
  input  wire logic                  se_plus_i,
  input  wire logic                  se_minus_i,
  output logic                       rx_bit_o,
  output logic                       rx_valid_o,
  output logic      [1:0]            line_state_o
);
  import usb_term_pkg::*;

  // ------------------------------------------------------------
  // overview
  // ------------------------------------------------------------

  // control fields arrive over the register port and steer the first two of three
  // independent parts that share only the clock and reset:
  //   - termination decode: five resistor enables from seven bits
  //   - receive path: receiver select, squelch gate, line state
  //   - transmit path: divider, serializer, stuffing, line coding
  // analog knobs for amplitude and squelch level are plain register
  // fields; the analog side applies them, this block only holds them
  // all outputs are registers, so the pins never glitch on a decode

  // ------------------------------------------------------------
  // termination decode
  // ------------------------------------------------------------

  // the five enables are a pure function of seven field bits; the
  // decode is a priority chain so that every code that no mode
  // names lands on the fallback set by the first assignments
  // hazards and intent:
  //   - line drive mode 01b is checked first, it overrides every field
  //   - host modes need both pulldown requests; the plus request
  //     alone is not a defined mode and falls back
  //   - peripheral modes need the plus request clear; the minus
  //     request then marks an on-the-go device and adds a pull-down
  //   - low speed with the minus request is not defined, falls back
  //   - line drive mode 11b matches no mode anywhere and falls back
  //   - the fallback keeps both pull-downs on so the lines never float
  // the function has no state, so the same decode serves the reset
  // value and the running value of the enables

  // table decode of the control fields into resistor enables
  function automatic term_en_s decode_term(input term_ctrl_s c);
    term_en_s t;
    logic     host;
    logic     periph;
    logic     otg;
    logic     op_n;
    logic     op_r;
    t      = '0;
    host   = c.plus_line_pulldown_request & c.minus_line_pulldown_request;
    periph = ~c.plus_line_pulldown_request;
    otg    = c.minus_line_pulldown_request;
    op_n   = (c.line_drive_mode == `OP_NORMAL);
    op_r   = (c.line_drive_mode == `OP_NO_NRZI);
    // fallback for anything not matched below
    t.plus_pulldown_enable  = 1'b1;
    t.minus_pulldown_enable = 1'b1;
    if (c.line_drive_mode == `OP_TRISTATE) begin
      t = '0;
    end else if (host) begin
      // host modes: both pulldown requests set
      if (c.transceiver_select == `XS_HS && !c.termination_select && (op_n || op_r)) begin
        t.highspeed_termination_enable = 1'b1;
      end else if (c.transceiver_select == `XS_FS && !c.termination_select && op_n) begin
        t.highspeed_termination_enable = 1'b0;
      end else if (c.transceiver_select[0] && c.termination_select && op_n) begin
        t.highspeed_termination_enable = 1'b0;
      end else if (c.transceiver_select == `XS_FS && c.termination_select && op_r) begin
        t.highspeed_termination_enable = 1'b0;
      end else if (c.transceiver_select == `XS_LS && c.termination_select && (op_n || op_r)) begin
        t.highspeed_termination_enable = 1'b0;
      end
    end else if (periph) begin
      // peripheral modes: plus request clear, minus request marks otg
      if (c.transceiver_select == `XS_HS && c.termination_select && op_r) begin
        t = '0;
        t.plus_pullup_enable = 1'b1;
        t.minus_pulldown_enable = otg;
      end else if (c.transceiver_select == `XS_HS && !c.termination_select && (op_n || op_r)) begin
        t = '0;
        t.highspeed_termination_enable = 1'b1;
        t.minus_pulldown_enable = otg;
      end else if (c.transceiver_select == `XS_FS && c.termination_select && (op_n || op_r)) begin
        t = '0;
        t.plus_pullup_enable = 1'b1;
        t.minus_pulldown_enable = otg;
      end else if (c.transceiver_select == `XS_LS && c.termination_select && (op_n || op_r) && !otg) begin
        t = '0;
        t.minus_pullup_enable = 1'b1;
      end else if (c.transceiver_select == `XS_FS && !c.termination_select && op_n && otg) begin
        t = '0;
        t.minus_pulldown_enable = 1'b1; // connect detect
      end
    end
    return t;
  endfunction

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------

  // three writable registers and one read-only status view
  //   - unused bits are dropped at the write, so they always read zero
  //   - writes to the status offset or unmapped offsets are ignored
  //   - the decode reads the next field values rather than the
  //     registers, so the enables change on the very edge that takes
  //     the write and never show one cycle of the old mode
  //   - read data are a register: zero when no read strobe was seen,
  //     so a stale word never sits on the bus

  logic [7:0]  func_reg;
  logic [7:0]  func_next;
  logic [7:0]  otg_reg;
  logic [7:0]  otg_next;
  logic [7:0]  comp_reg;
  term_ctrl_s  ctrl_next;
  logic        hs_mode;

  // next values of the writable registers
  always_comb begin
    func_next = func_reg;
    otg_next  = otg_reg;
    if (wr_i && addr_i == `ADDR_FUNC_CTRL) begin
      func_next = {3'h0, wdata_i[4:0]};
    end
    if (wr_i && addr_i == `ADDR_OTG_CTRL) begin
      otg_next = {6'h00, wdata_i[1:0]};
    end
  end

  // decode input gathered from the next field values only
  always_comb begin
    ctrl_next.transceiver_select          = func_next[`FC_XS_LSB +: 2];
    ctrl_next.termination_select          = func_next[`FC_TS_BIT];
    ctrl_next.line_drive_mode             = func_next[`FC_OP_LSB +: 2];
    ctrl_next.plus_line_pulldown_request  = otg_next[`OC_DP_BIT];
    ctrl_next.minus_line_pulldown_request = otg_next[`OC_DM_BIT];
  end

  // control registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      func_reg <= `RST_FUNC_CTRL;
      otg_reg  <= `RST_OTG_CTRL;
    end else begin
      func_reg <= func_next;
      otg_reg  <= otg_next;
    end
  end

  // enables update on the same edge as the fields
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      term_o <= decode_term(term_ctrl_s'({2'h1, 1'b0, 2'h0, 1'b1, 1'b1}));
    end else begin
      term_o <= decode_term(ctrl_next);
    end
  end

  // compensation register drives the analog knobs
  // the knobs change only on a write; the analog side must tolerate
  // a step in amplitude or squelch level while a packet is on the line
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      comp_reg <= `RST_COMP;
    end else if (wr_i && addr_i == `ADDR_COMP) begin
      comp_reg <= {1'b0, wdata_i[6:4], 1'b0, wdata_i[2:0]};
    end
  end

  assign tx_amplitude_boost_o   = comp_reg[`CP_BOOST_LSB +: 3];
  assign squelch_level_adjust_o = comp_reg[`CP_SQL_LSB +: 3];

  // read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_i) begin
    if (reset_i || !rd_i) begin
      rdata_o <= 8'h00;
    end else begin
      unique case (addr_i)
        `ADDR_FUNC_CTRL: rdata_o <= func_reg;
        `ADDR_OTG_CTRL:  rdata_o <= otg_reg;
        `ADDR_COMP:      rdata_o <= comp_reg;
        `ADDR_STATUS:    rdata_o <= {term_o, squelch_i, se_minus_i, se_plus_i};
        default:         rdata_o <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // receive path
  // ------------------------------------------------------------

  // every receive output is one register stage behind its input
  //   - the select uses the stored transceiver select, so a write that
  //     changes speed takes effect one cycle after the write edge
  //   - squelch high means the line is below threshold; in high speed
  //     the valid flag drops so noise is never passed as data
  //   - outside high speed the full-speed receiver has no squelch and
  //     valid stays high

  assign hs_mode = (func_reg[`FC_XS_LSB +: 2] == `XS_HS);

  // receiver select, squelch gate and line state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_bit_o     <= 1'b0;
      rx_valid_o   <= 1'b0;
      line_state_o <= 2'h0;
    end else begin
      rx_bit_o     <= hs_mode ? hs_rx_i : fs_rx_i;
      rx_valid_o   <= hs_mode ? ~squelch_i : 1'b1;
      line_state_o <= {se_minus_i, se_plus_i};
    end
  end

  // ------------------------------------------------------------
  // transmit path
  // ------------------------------------------------------------

  // the serializer runs on a bit enable from a free running divider
  //   - a word is taken only while ready is high and the state is idle
  //   - bits leave lsb first; a zero toggles the line, a one holds it
  //   - the run of ones is counted across words, so a stuffed zero may
  //     fall inside the next word or after the last bit
  //   - when the sixth one is the last bit of a word, the stuffed zero
  //     follows in the stuff state before ready returns
  //   - the first bit waits for the next divider pulse, so the start
  //     of a word jitters by up to one bit time

  logic [3:0]  div_reg;
  logic        bit_en;
  tx_state_e   tx_state_reg;
  logic [7:0]  shift_reg;
  logic [2:0]  bit_cnt_reg;
  logic [2:0]  ones_reg;

  assign bit_en = (div_reg == `BIT_DIV - 4'h1);

  // bit rate enable divider
  always_ff @(posedge clk_i) begin
    if (reset_i || bit_en) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  // load word, stuff a zero after six ones, shift lsb first, nrzi out
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_state_reg <= TX_IDLE;
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 3'h0;
      ones_reg     <= 3'h0;
      tx_line_o    <= 1'b1;
      tx_active_o  <= 1'b0;
      tx_ready_o   <= 1'b1;
    end else begin
      unique case (tx_state_reg)
        // wait for a word
        TX_IDLE: begin
          if (tx_valid_i) begin
            shift_reg    <= tx_data_i;
            bit_cnt_reg  <= 3'h0;
            tx_state_reg <= TX_DATA;
            tx_active_o  <= 1'b1;
            tx_ready_o   <= 1'b0;
          end
        end
        // shift one bit per enable and count the run of ones
        TX_DATA: begin
          if (bit_en) begin
            shift_reg   <= {1'b0, shift_reg[7:1]};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (!shift_reg[0]) begin
              tx_line_o <= ~tx_line_o;
              ones_reg  <= 3'h0;
            end else begin
              ones_reg  <= ones_reg + 3'h1;
            end
            if (shift_reg[0] && ones_reg == `STUFF_RUN - 3'h1) begin
              tx_state_reg <= TX_STUFF;
            end else if (bit_cnt_reg == 3'h7) begin
              tx_state_reg <= TX_IDLE;
              tx_active_o  <= 1'b0;
              tx_ready_o   <= 1'b1;
            end
          end
        end
        // insert the stuffed zero, then resume or finish the word
        TX_STUFF: begin
          if (bit_en) begin
            tx_line_o <= ~tx_line_o;
            ones_reg  <= 3'h0;
            if (bit_cnt_reg == 3'h0) begin
              tx_state_reg <= TX_IDLE;
              tx_active_o  <= 1'b0;
              tx_ready_o   <= 1'b1;
            end else begin
              tx_state_reg <= TX_DATA;
            end
          end
        end
        // the unused code recovers to idle
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> sim/usb_termination_decode_monitor.sv
`timescale 1ns/1ns
`include "usb_term_cfg.svh"
// ----------------------------------------
// termination decode checker
// ----------------------------------------
module usb_termination_decode_monitor (
  input wire logic                   clk_i,
  input wire logic                   reset_i,
  input wire logic [3:0]             addr_i,
  input wire logic [7:0]             wdata_i,
  input wire logic                   wr_i,
  input wire logic                   rd_i,
  input wire logic [7:0]             rdata_o,
  input wire usb_term_pkg::term_en_s term_o,
  input wire logic [2:0]             tx_amplitude_boost_o,
  input wire logic [2:0]             squelch_level_adjust_o,
  input wire logic                   tx_valid_i,
  input wire logic                   tx_ready_o,
  input wire logic                   tx_active_o,
  input wire logic                   hs_rx_i,
  input wire logic                   fs_rx_i,
  input wire logic                   squelch_i,
  input wire logic                   se_plus_i,
  input wire logic                   se_minus_i,
  input wire logic                   rx_bit_o,
  input wire logic                   rx_valid_o,
  input wire logic [1:0]             line_state_o
);
  import usb_term_pkg::*;
  logic [4:0] func_reg;
  logic [1:0] otg_reg;
  logic       sel_rx;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // shadow of the control fields, taken from the write strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      func_reg <= 5'h01;
      otg_reg <= 2'h3;
    end else if (wr_i && addr_i == `ADDR_FUNC_CTRL) begin
      func_reg <= wdata_i[4:0];
    end else if (wr_i && addr_i == `ADDR_OTG_CTRL) begin
      otg_reg <= wdata_i[1:0];
    end
  end
  // receiver that the speed mode should pick
  assign sel_rx = (func_reg[1:0] == `XS_HS) ? hs_rx_i : fs_rx_i;
  AST_TRISTATE: assert property (func_reg[4:3] == `OP_TRISTATE |-> term_o == 5'h00)
    else $error("termination not cleared in tristate mode");
  AST_HOST_PD: assert property (otg_reg == 2'h3 && func_reg[4:3] != `OP_TRISTATE
    |-> term_o.plus_pulldown_enable && term_o.minus_pulldown_enable)
    else $error("host pull-downs missing");
  AST_NO_PULLUP: assert property (otg_reg[0] |-> !term_o.plus_pullup_enable && !term_o.minus_pullup_enable)
    else $error("pull-up with plus pulldown request");
  AST_HS_TERM: assert property (term_o.highspeed_termination_enable |-> func_reg[1:0] == `XS_HS)
    else $error("high-speed termination outside high-speed select");
  AST_COMP: assert property (wr_i && addr_i == `ADDR_COMP |=> tx_amplitude_boost_o == $past(wdata_i[2:0])
    && squelch_level_adjust_o == $past(wdata_i[6:4]))
    else $error("compensation outputs do not follow write");
  AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  AST_TX_TAKE: assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o && tx_active_o)
    else $error("transmit word not taken");
  AST_TX_DONE: assert property ($rose(tx_active_o) |-> ##[1:60] tx_ready_o)
    else $error("transmit word never finished");
  AST_RX_MUX: assert property (!$past(reset_i) |-> rx_bit_o == $past(sel_rx))
    else $error("wrong receiver selected");
  AST_SQUELCH: assert property (!$past(reset_i) && $past(func_reg[1:0]) == `XS_HS
    |-> rx_valid_o == !$past(squelch_i))
    else $error("squelch not gating receive");
  AST_LINE: assert property (!$past(reset_i) |-> line_state_o == {$past(se_minus_i), $past(se_plus_i)})
    else $error("line state mismatch");
endmodule

// >>> sim/line_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// cable side receivers
// ----------------------------------------
module line_model (
  input  wire logic clk_i,
  output logic      hs_rx_o,
  output logic      fs_rx_o,
  output logic      squelch_o,
  output logic      se_plus_o,
  output logic      se_minus_o
);
  logic [4:0] rx_reg = 5'h00;
  // line noise and data change every cycle so stale values never pass
  always @(posedge clk_i) begin
    rx_reg <= 5'($urandom);
  end
  assign {hs_rx_o, fs_rx_o, squelch_o, se_plus_o, se_minus_o} = rx_reg;
endmodule

// >>> sim/usb_termination_decode_test.sv
`timescale 1ns/1ns
`include "usb_term_cfg.svh"
// ----------------------------------------
// termination decode bench
// ----------------------------------------
module usb_termination_decode_test;
  import usb_term_pkg::*;
  logic clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, tx_valid_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, tx_data_i = 8'h00, rdata_o, w, f;
  logic [2:0] boost, sql;
  logic tx_ready_o, tx_active_o, tx_line_o, hs, fs, sq, sp, sm, rx_bit, rx_valid;
  logic [1:0] line_state;
  term_en_s term_o;
  int failures = 0, checks = 0, tog = 0;
  logic rd_d = 1'b0, line_d = 1'b1, rdy_d = 1'b1;
  logic [15:0] q[$], e;
  logic [7:0] tq[$];
  // rows: select, termination, mode, otg field, expected enables
  logic [11:0] tbl[17] = '{12'h466, 12'he80, 12'h167, 12'h067, 12'he66, 12'h766, 12'hb66, 12'h310,
                          12'h001, 12'h610, 12'hb08, 12'h652, 12'h043, 12'h266, 12'h786, 12'h442,
                          12'ha66};
  always #50 clk_i = ~clk_i;
  usb_termination_decode usb_termination_decode_i (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .term_o, .tx_amplitude_boost_o(boost), .squelch_level_adjust_o(sql), .tx_data_i,
    .tx_valid_i, .tx_ready_o, .tx_line_o, .tx_active_o, .hs_rx_i(hs), .fs_rx_i(fs), .squelch_i(sq),
    .se_plus_i(sp), .se_minus_i(sm), .rx_bit_o(rx_bit), .rx_valid_o(rx_valid), .line_state_o(line_state));
  line_model line_model_i (.clk_i, .hs_rx_o(hs), .fs_rx_o(fs), .squelch_o(sq), .se_plus_o(sp),
    .se_minus_o(sm));
  // compare one value and count it
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] s);
    checks++;
    if (x !== s) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read, noting mask and expected value
  task automatic rd(input logic [3:0] a, input logic [15:0] me);
    q.push_back(me);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  // send one word and wait for the serializer to go idle
  task automatic send(input logic [7:0] d, input logic [7:0] n);
    tq.push_back(n);
    @(posedge clk_i);
    tx_valid_i <= 1'b1;
    tx_data_i <= d;
    @(posedge clk_i);
    tx_valid_i <= 1'b0;
    @(negedge clk_i);
    for (int k = 0; k < 300 && tx_ready_o !== 1'b1; k++) @(negedge clk_i);
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // result watcher: read data, enables and line toggles per word
  always @(posedge clk_i) begin
    if (rd_d) begin
      e = q.pop_front();
      chk("rdata", e[7:0], rdata_o & e[15:8]);
      if (e[15:8] == 8'hf8) chk("term", e[7:0], {term_o, 3'h0});
    end
    if (!reset_i && tx_line_o !== line_d) tog++;
    if (tx_ready_o === 1'b1 && !rdy_d) begin
      chk("toggles", tq.pop_front(), 8'(tog));
      tog = 0;
    end
    rd_d <= rd_i;
    line_d <= tx_line_o;
    rdy_d <= (tx_ready_o === 1'b1);
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    complete_run();
  end
  // main sequence
  initial begin
    void'($urandom(32'hbd1f));
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`ADDR_FUNC_CTRL, 16'hff01);
    rd(`ADDR_OTG_CTRL, 16'hff03);
    rd(`ADDR_STATUS, 16'hf830);
    wr(4'h9, 8'hff);
    rd(4'h9, 16'hff00);
    foreach (tbl[i]) begin
      f = {3'h0, tbl[i][8:7], tbl[i][9], tbl[i][11:10]};
      wr(`ADDR_FUNC_CTRL, f);
      wr(`ADDR_OTG_CTRL, {6'h0, tbl[i][6:5]});
      rd(`ADDR_FUNC_CTRL, {8'hff, f});
      rd(`ADDR_STATUS, {8'hf8, tbl[i][4:0], 3'h0});
    end
    wr(`ADDR_STATUS, 8'h00);
    rd(`ADDR_STATUS, 16'hf830);
    for (int i = 0; i < 3; i++) begin
      w = 8'($urandom);
      wr(`ADDR_COMP, w);
      rd(`ADDR_COMP, {8'hff, w & 8'h77});
    end
    send(8'h00, 8'h08);
    send(8'hff, 8'h01);
    send(8'hff, 8'h01);
    send(8'hff, 8'h02);
    repeat (4) @(posedge clk_i);
    complete_run();
  end
endmodule
bind usb_termination_decode usb_termination_decode_monitor usb_termination_decode_monitor_i (.clk_i, .reset_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .term_o, .tx_amplitude_boost_o, .squelch_level_adjust_o,
  .tx_valid_i, .tx_ready_o, .tx_active_o, .hs_rx_i, .fs_rx_i, .squelch_i, .se_plus_i, .se_minus_i,
  .rx_bit_o, .rx_valid_o, .line_state_o);
